// ---- bench/mad_checker.sv ----
// assertion checker bound to the memory attribute decoder top
`timescale 1ns/100ps
`include "mad_map.vh"
module mad_checker (
  // clock, reset and register writes
  input wire mclk, sys_rst, reg_wr,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  // access, fetch and completion inputs
  input wire acc_valid, acc_store, acc_load, acc_hit, mem_idle, ext_abort, fetch_valid, xlat_fetch_fault,
  input wire [1:0] acc_size, acc_addr_low,
  input wire [2:0] acc_flags,
  // design outputs
  input wire attr_cacheable, attr_bufferable, attr_write_back, attr_use_mini, wb_merge_ok, line_fill_req,
  input wire acc_accept, pipe_stall, data_abort, prefetch_abort, imprecise_abort,
  input wire [5:0] line_fill_bytes
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // =====================
  // shadow of the control enables
  logic xon, aon;
  always @(posedge mclk) begin
    if (sys_rst) begin
      xon <= 1'b0;
      aon <= 1'b0;
    end else if (reg_wr && reg_addr == `MAD_OFF_CTRL) begin
      xon <= reg_wdata[`MAD_CTRL_XLAT_BIT];
      aon <= reg_wdata[`MAD_CTRL_ALIGN_BIT];
    end
  end
  // accepted access that must complete before execution goes on
  sequence s_sync;
    acc_accept && (acc_flags == 3'h0 || !xon) && !data_abort;
  endsequence
  // =====================
  // properties
  AST_UNCACHED: assert property (
    acc_valid && (acc_flags == 3'h0 || !xon) |-> !attr_cacheable && !attr_bufferable) else $error("uncached bad");
  AST_X0: assert property (
    acc_valid && xon && !acc_flags[2] |-> attr_cacheable == acc_flags[1] && attr_bufferable == (acc_flags != 3'h0)
    && attr_write_back == (acc_flags == 3'h3)) else $error("x0 decode bad");
  AST_X101: assert property (
    acc_valid && xon && acc_flags == 3'h5 |-> !attr_cacheable && attr_bufferable && !wb_merge_ok) else $error("101 bad");
  AST_X11: assert property (
    acc_valid && xon && acc_flags[2:1] == 2'h3 |-> attr_cacheable && attr_use_mini == !acc_flags[0])
    else $error("x11 decode bad");
  AST_SYNC_STALL: assert property (s_sync |=> pipe_stall) else $error("no stall");
  AST_IMPRECISE: assert property (
    s_sync ##[1:2] (ext_abort && pipe_stall) |=> imprecise_abort) else $error("abort not imprecise");
  AST_FENCE: assert property (
    acc_accept && xon && acc_load && !acc_flags[1] |-> mem_idle) else $error("fence passed early");
  AST_ALIGN: assert property (
    acc_valid && aon && acc_size == 2'h2 && acc_addr_low != 2'h0 |-> data_abort) else $error("no align fault");
  AST_QUIET: assert property (!xon && !aon |-> !prefetch_abort && !data_abort) else $error("abort off");
  AST_FETCH: assert property (
    xon && fetch_valid && xlat_fetch_fault |-> prefetch_abort) else $error("no prefetch abort");
  AST_LINE: assert property (
    acc_accept && xon && acc_store && !acc_hit && acc_flags == 3'h7 && !data_abort |-> line_fill_req
    && line_fill_bytes == 6'h20) else $error("no line fill");
endmodule
bind mad_top mad_checker chk_u (.*);

// ---- bench/mad_lsu_model.sv ----
// load/store pipeline and memory completion model facing the decoder
`timescale 1ns/100ps
module mad_lsu_model (
  // clock, reset and bench commands
  input wire mclk, sys_rst, go, slow,
  input wire [3:0] kind, adr,
  input wire [2:0] flg,
  // access handshake toward the decoder
  input wire acc_accept,
  output logic acc_valid, acc_hit, acc_load, acc_store, acc_swap,
  output logic [1:0] acc_size, acc_addr_low,
  output logic [2:0] acc_flags,
  output wire mem_idle
);
  logic [3:0] busy; // cycles until earlier memops are done
  assign mem_idle = busy == 4'h0;
  initial {acc_valid, acc_hit, acc_load, acc_store, acc_swap, acc_size, acc_addr_low, acc_flags} = 12'h0;
  // =====================
  // hold each access until taken, then scramble the released fields
  always @(posedge mclk) begin
    if (sys_rst) begin
      acc_valid <= 1'b0;
      busy <= 4'h0;
    end else begin
      if (go) begin
        acc_valid <= 1'b1;
        {acc_hit, acc_load, acc_store, acc_swap} <= kind;
        {acc_size, acc_addr_low} <= adr;
        acc_flags <= flg;
      end else if (acc_accept) begin
        acc_valid <= 1'b0;
        {acc_size, acc_addr_low, acc_flags} <= ~{acc_size, acc_addr_low, acc_flags};
      end
      // slow or prompt completion of each accepted memop
      if (acc_accept)
        busy <= slow ? 4'h6 : 4'h1;
      else if (busy != 4'h0)
        busy <= busy - 4'h1;
    end
  end
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the memory attribute decoder
`timescale 1ns/100ps
module tb;
  // clock, reset and register port
  logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  // model commands and fault inputs
  logic go = 1'b0, slow = 1'b0, xlat_data_fault = 1'b0, fetch_valid = 1'b0, xlat_fetch_fault = 1'b0;
  logic ext_abort = 1'b0, xon = 1'b0, aon = 1'b0, ma, i0;
  logic [3:0] kind = 4'h0, adr = 4'h0, a;
  logic [2:0] flg = 3'h0, f;
  logic [1:0] pol = 2'h0;
  logic [19:0] fk = 20'h42112; // fence kinds
  logic [14:0] fl = 15'o01510; // fence flags
  int errors = 0, num_checks = 0, cyc = 0;
  wire acc_valid, acc_load, acc_store, acc_swap, acc_hit, mem_idle, acc_accept, irq, line_fill_req;
  wire attr_cacheable, attr_bufferable, attr_write_back, attr_use_mini, wb_merge_ok;
  wire pipe_stall, data_abort, prefetch_abort, imprecise_abort;
  wire [1:0] acc_size, acc_addr_low;
  wire [2:0] acc_flags;
  wire [5:0] line_fill_bytes;
  mad_top dut_u (.*);
  mad_lsu_model lsu_u (.*);
  always #2 mclk = ~mclk;
  // =====================
  // helpers
  function automatic void chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endfunction
  // expected {cacheable, bufferable, write back, mini}
  function automatic [3:0] ea(input [2:0] x);
    if (!xon) return 4'h0;
    case (x)
      3'h1, 3'h5: return 4'h4;
      3'h2: return 4'hc;
      3'h3, 3'h7: return 4'he;
      3'h6: return {2'h3, pol != 2'h2, 1'b1};
      default: return 4'h0;
    endcase
  endfunction
  task automatic wr(input [7:0] ad, input [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input [7:0] ad, output [31:0] d);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask
  // hand one access to the model and wait until it is taken
  task automatic issue(input [3:0] k, input [2:0] fx, input [3:0] ad, input s);
    go <= 1'b1;
    kind <= k;
    flg <= fx;
    adr <= ad;
    slow <= s;
    @(posedge mclk);
    go <= 1'b0;
    repeat (40) begin
      @(negedge mclk);
      if (!acc_valid) break;
    end
    chk("taken", 32'h0, 32'(acc_valid));
    @(posedge mclk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // =====================
  // decode of every accepted access
  always @(posedge mclk) begin
    if (!sys_rst && acc_accept) begin
      a = ea(acc_flags);
      ma = aon && (acc_size == 2'h1 && acc_addr_low[0] || acc_size == 2'h2 && acc_addr_low != 2'h0);
      chk("attr", 32'(a), 32'({attr_cacheable, attr_bufferable, attr_write_back, attr_use_mini}));
      chk("abort", 32'(ma || xon && xlat_data_fault), 32'(data_abort));
      if (!xon || acc_flags == 3'h0 || (acc_load || acc_swap) && !acc_flags[1] || (acc_store || acc_swap) && acc_flags == 3'h5)
        chk("fence", 32'h1, 32'(mem_idle));
      if (acc_store)
        chk("merge", 32'(a[2] && !a[1] && acc_flags != 3'h5), 32'(wb_merge_ok));
      if (!acc_swap && !data_abort && (acc_flags == 3'h2 || acc_flags[1:0] == 2'h3))
        chk("fill", 32'(!acc_hit && a[3] && (acc_load || acc_flags == 3'h7)), 32'(line_fill_req));
    end
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      results;
    end
  end
  // =====================
  // main sequence
  initial begin
    void'($urandom(32'h504b));
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4), v);
      chk("reset", 32'h0, v);
    end
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, v);
    chk("unmapped", 32'h0, v);
    $display("test registers done");
    for (int i = 0; i < 64; i++) begin
      if (i % 16 == 0) begin
        wr(8'h00, 32'(i / 16));
        xon = (i / 16) % 2;
        aon = i >= 32;
      end
      pol = 2'($urandom);
      wr(8'h04, {26'h0, pol, 4'h0});
      do f = 3'($urandom); while (f == 3'h4);
      xlat_data_fault <= 1'($urandom);
      issue({1'($urandom), 3'h1 << ($urandom % 3)}, f, {2'($urandom % 3), 2'($urandom)}, 1'($urandom));
    end
    $display("test sweep done");
    xlat_data_fault <= 1'b0;
    wr(8'h00, 32'h1);
    xon = 1'b1;
    aon = 1'b0;
    for (int i = 0; i < 5; i++) begin
      issue(4'h2, 3'h3, 4'h8, 1'b1);
      issue(fk[i * 4 +: 4], fl[i * 3 +: 3], 4'h8, 1'b0);
    end
    issue(4'h2, 3'h7, 4'h8, 1'b0);
    issue(4'h4, 3'h2, 4'h8, 1'b0);
    $display("test fences done");
    wr(8'h08, 32'h1f);
    issue(4'h2, 3'h0, 4'h8, 1'b1);
    ext_abort <= 1'b1;
    @(posedge mclk);
    ext_abort <= 1'b0;
    @(negedge mclk);
    chk("stall", 32'h1, 32'(pipe_stall));
    chk("imprecise", 32'h1, 32'(imprecise_abort));
    @(posedge mclk);
    rd(8'h08, v);
    chk("status", 32'h1, 32'(v[3]));
    wr(8'h0c, 32'h0);
    @(negedge mclk);
    i0 = irq;
    @(posedge mclk);
    wr(8'h0c, 32'h1f);
    @(negedge mclk);
    chk("irq mask", 32'(!i0), 32'(irq));
    @(posedge mclk);
    wr(8'h08, 32'h1f);
    rd(8'h08, v);
    chk("cleared", 32'h0, 32'(v[4:0]));
    chk("irq", 32'h0, 32'(irq));
    $display("test abort done");
    fetch_valid <= 1'b1;
    xlat_fetch_fault <= 1'b1;
    @(negedge mclk);
    chk("pabort", 32'h1, 32'(prefetch_abort));
    @(posedge mclk);
    wr(8'h00, 32'h0);
    chk("pabort off", 32'h0, 32'(prefetch_abort));
    $display("test fetch done");
    results;
  end
endmodule

// ---- hdl/mad_attr_dec.v ----
// combinational decode of the three attribute flags into cache and buffer behaviour
`timescale 1ns/100ps
`include "mad_map.vh"
module mad_attr_dec (
  // descriptor flags
  input wire xflag,
  input wire cflag,
  input wire bflag,
  // translation state and mini cache policy
  input wire xlat_on,
  input wire [1:0] small_store_policy_field,
  // decoded behaviour
  output reg cacheable,
  output reg bufferable,
  output reg write_back,
  output reg alloc_on_write,
  output reg use_mini,
  output reg no_coalesce,
  output reg stall_complete,
  output reg bad_encoding
);
  // purely combinational decode, valid with the translation result (see R18)
  always @* begin
    cacheable = 1'b0;
    bufferable = 1'b0;
    write_back = 1'b0;
    alloc_on_write = 1'b0;
    use_mini = 1'b0;
    no_coalesce = 1'b0;
    stall_complete = 1'b0;
    bad_encoding = 1'b0;
    if (!xlat_on) begin
      // translation off: same as the all zero encoding (see R16)
      stall_complete = 1'b1;
    end else begin
      case ({xflag, cflag, bflag})
        // uncached, unbuffered, stall until complete (see R01)
        3'h0: stall_complete = 1'b1;
        // bufferable only (see R02)
        3'h1: bufferable = 1'b1;
        // write-through, read allocate (see R02)
        3'h2: begin
          cacheable = 1'b1;
          bufferable = 1'b1;
        end
        // write-back, read allocate (see R02)
        3'h3: begin
          cacheable = 1'b1;
          bufferable = 1'b1;
          write_back = 1'b1;
        end
        // forbidden encoding, flagged and treated as uncached (see R04)
        3'h4: begin
          bad_encoding = 1'b1;
          stall_complete = 1'b1;
        end
        // bufferable, never merge in the write buffer (see R05)
        3'h5: begin
          bufferable = 1'b1;
          no_coalesce = 1'b1;
        end
        // mini data cache, policy from auxiliary field (see R07)
        3'h6: begin
          use_mini = 1'b1;
          cacheable = 1'b1;
          bufferable = 1'b1;
          write_back = (small_store_policy_field != `MAD_POL_WT_RA);
          alloc_on_write = (small_store_policy_field == `MAD_POL_WB_RWA);
        end
        // write-back, read/write allocate (see R08)
        default: begin
          cacheable = 1'b1;
          bufferable = 1'b1;
          write_back = 1'b1;
          alloc_on_write = 1'b1;
        end
      endcase
    end
  end
endmodule

// ---- hdl/mad_fence_chk.v ----
// fence and fault classification of one data access
`timescale 1ns/100ps
module mad_fence_chk (
  // access
  input wire is_load,
  input wire is_store,
  input wire is_swap,
  input wire [1:0] size_log2,
  input wire [1:0] addr_low,
  // attributes and control
  input wire xflag,
  input wire cflag,
  input wire bflag,
  input wire xlat_on,
  input wire align_on,
  // classification
  output wire fence,
  output wire misaligned
);
  // fence when a load or store under these flags would be one
  function fence_of;
    input ld;
    input st;
    input [2:0] f;
    begin
      fence_of = (ld && !f[1]) || (st && f == 3'h5) || ((ld || st) && f == 3'h0);
    end
  endfunction
  wire [2:0] flags;
  // disabled translation acts as the all zero encoding
  assign flags = xlat_on ? {xflag, cflag, bflag} : 3'h0;
  // loads, stores and swaps (see R10) (see R11)
  assign fence = fence_of(is_load, is_store, flags) || (is_swap && fence_of(1'b1, 1'b1, flags));
  // alignment only while enabled, regardless of translation (see R12) (see R13)
  assign misaligned = align_on && (is_load || is_store || is_swap) &&
    (((size_log2 == 2'h1) && addr_low[0]) || ((size_log2 == 2'h2) && (addr_low != 2'h0)));
endmodule

// ---- hdl/mad_top.v ----
// memory attribute decoder: attribute decode, fences, aborts and registers
//
// Behaviour
// R01: all flags zero: uncached, unbuffered, stall until done
// R02: x clear: 01 buffered, 10 WT, 11 WB
// R03: stall-until-complete external aborts are reported imprecise
// R04: producers never program x set with c,b clear
// R05: x,0,1: buffered, writes never merge
// R06: ordinary bufferable writes merge in write buffer
// R07: x,1,0: mini cache, policy from auxiliary field
// R08: all flags set: WB, read/write allocate
// R09: fence orders earlier memops before later ones
// R10: fences: load c clear, store 101, 000
// R11: swap is fence where load/store would be
// R12: alignment check only while control bit 1 set
// R13: alignment faults reported even with translation off
// R14: translation off suppresses all other translation faults
// R15: prefetch aborts for fetches, data aborts for data
// R16: translation off: data uncached and unbuffered
// R17: allocating miss fetches a 32 byte line
// R18: attribute decode is combinational, same cycle
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "mad_map.vh"
module mad_top (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // data access from the load/store pipeline
  input wire acc_valid,
  input wire acc_load,
  input wire acc_store,
  input wire acc_swap,
  input wire [1:0] acc_size,
  input wire [1:0] acc_addr_low,
  input wire acc_hit,
  input wire [2:0] acc_flags,
  // translation result faults
  input wire xlat_data_fault,
  input wire fetch_valid,
  input wire xlat_fetch_fault,
  // external data abort and completion of outstanding memops
  input wire ext_abort,
  input wire mem_idle,
  // decoded attributes to caches and write buffer
  output wire attr_cacheable,
  output wire attr_bufferable,
  output wire attr_write_back,
  output wire attr_use_mini,
  output wire wb_merge_ok,
  output wire line_fill_req,
  output wire [5:0] line_fill_bytes,
  // pipeline control and aborts
  output wire pipe_stall,
  output wire acc_accept,
  output wire data_abort,
  output wire prefetch_abort,
  output reg imprecise_abort,
  output wire irq
);
  // =====================================
  // registers
  reg [31:0] ctrl_reg; // control register
  reg [31:0] aux_reg; // auxiliary control
  reg [4:0] status_reg; // sticky event bits
  reg [4:0] mask_reg; // interrupt enables
  reg [15:0] fence_cnt_reg; // number of fences taken
  reg stall_pend_reg; // a stall-until-complete access is outstanding
  reg fence_pend_reg; // a fence waits for earlier memops
  reg [4:0] status_next;
  wire xlat_on;
  wire align_on;
  wire [1:0] pol;
  wire dec_write_back;
  wire dec_alloc_wr;
  wire dec_no_coal;
  wire dec_stall;
  wire dec_bad;
  wire dec_cache;
  wire dec_buf;
  wire is_fence;
  wire misaligned;
  wire hold;
  wire take;
  wire [4:0] ev;
  wire [4:0] clr;
  assign xlat_on = ctrl_reg[`MAD_CTRL_XLAT_BIT];
  assign align_on = ctrl_reg[`MAD_CTRL_ALIGN_BIT];
  assign pol = aux_reg[`MAD_AUX_POL_MSB:`MAD_AUX_POL_LSB];
  // =====================================
  // attribute decode
  mad_attr_dec u_dec (
    .xflag(acc_flags[2]),
    .cflag(acc_flags[1]),
    .bflag(acc_flags[0]),
    .xlat_on(xlat_on),
    .small_store_policy_field(pol),
    .cacheable(dec_cache),
    .bufferable(dec_buf),
    .write_back(dec_write_back),
    .alloc_on_write(dec_alloc_wr),
    .use_mini(attr_use_mini),
    .no_coalesce(dec_no_coal),
    .stall_complete(dec_stall),
    .bad_encoding(dec_bad)
  );
  // =====================================
  // fence and alignment check
  mad_fence_chk u_fence (
    .is_load(acc_load),
    .is_store(acc_store),
    .is_swap(acc_swap),
    .size_log2(acc_size),
    .addr_low(acc_addr_low),
    .xflag(acc_flags[2]),
    .cflag(acc_flags[1]),
    .bflag(acc_flags[0]),
    .xlat_on(xlat_on),
    .align_on(align_on),
    .fence(is_fence),
    .misaligned(misaligned)
  );
  assign attr_cacheable = dec_cache;
  assign attr_bufferable = dec_buf;
  assign attr_write_back = dec_write_back;
  // merge only for ordinary bufferable stores (see R06) (see R05)
  assign wb_merge_ok = acc_valid && acc_store && dec_buf && !dec_no_coal && !dec_write_back;
  // =====================================
  // access flow: fences and stall-until-complete hold the pipe until memory is idle
  // a fence waits for all earlier memops; later ones are held (see R09)
  assign hold = stall_pend_reg || (acc_valid && is_fence && !mem_idle);
  assign pipe_stall = hold;
  assign take = acc_valid && !hold;
  assign acc_accept = take;
  // line fill on allocating miss, load always, store under read/write allocate (see R17)
  assign line_fill_req = take && dec_cache && !acc_hit && (acc_load || acc_swap || (acc_store && dec_alloc_wr));
  assign line_fill_bytes = `MAD_LINE_BYTES;
  // data abort: alignment while enabled, translation faults only while on (see R13) (see R14) (see R15)
  assign data_abort = acc_valid && (misaligned || (xlat_on && xlat_data_fault));
  // prefetch abort on faulting fetch while translation is on (see R14) (see R15)
  assign prefetch_abort = fetch_valid && xlat_on && xlat_fetch_fault;
  // stall-until-complete tracking (see R01)
  always @(posedge mclk) begin
    if (sys_rst) begin
      stall_pend_reg <= 1'b0;
      fence_pend_reg <= 1'b0;
      fence_cnt_reg <= 16'h0000;
    end else begin
      if (take && dec_stall && !data_abort) begin
        stall_pend_reg <= 1'b1;
      end else if (mem_idle) begin
        stall_pend_reg <= 1'b0;
      end
      fence_pend_reg <= acc_valid && is_fence && !mem_idle;
      if (take && is_fence) begin
        fence_cnt_reg <= fence_cnt_reg + 16'h0001;
      end
    end
  end
  // external abort during stall-until-complete access is imprecise (see R03)
  always @(posedge mclk) begin
    if (sys_rst) begin
      imprecise_abort <= 1'b0;
    end else begin
      imprecise_abort <= ext_abort && stall_pend_reg;
    end
  end
  // =====================================
  // interrupt status: set wins over write-one clear
  assign ev[`MAD_ST_ALIGN] = acc_valid && misaligned;
  assign ev[`MAD_ST_DABORT] = acc_valid && xlat_on && xlat_data_fault;
  assign ev[`MAD_ST_PABORT] = prefetch_abort;
  assign ev[`MAD_ST_IMPRECISE] = ext_abort && stall_pend_reg;
  // report forbidden encodings seen (see R04)
  assign ev[`MAD_ST_BADENC] = acc_valid && dec_bad;
  assign clr = (reg_wr && reg_addr == `MAD_OFF_STATUS) ? reg_wdata[4:0] : 5'h00;
  always @* begin
    status_next = (status_reg & ~clr) | ev;
  end
  assign irq = |(status_reg & mask_reg);
  // =====================================
  // register writes
  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg <= `MAD_CTRL_RST;
      aux_reg <= `MAD_AUX_RST;
      mask_reg <= `MAD_MASK_RST;
      status_reg <= 5'h00;
    end else begin
      status_reg <= status_next;
      if (reg_wr) begin
        case (reg_addr)
          `MAD_OFF_CTRL: ctrl_reg <= {30'h0, reg_wdata[1:0]};
          `MAD_OFF_AUX: aux_reg <= {26'h0, reg_wdata[5:4], 4'h0};
          `MAD_OFF_MASK: mask_reg <= reg_wdata[4:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end
  // =====================================
  // register reads, data one cycle later, unmapped reads zero
  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `MAD_OFF_CTRL: reg_rdata <= ctrl_reg;
        `MAD_OFF_AUX: reg_rdata <= aux_reg;
        `MAD_OFF_STATUS: reg_rdata <= {27'h0, status_reg};
        `MAD_OFF_MASK: reg_rdata <= {27'h0, mask_reg};
        `MAD_OFF_FENCE_CNT: reg_rdata <= {14'h0, fence_pend_reg, stall_pend_reg, fence_cnt_reg};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// ---- inc/mad_map.vh ----
// constants of the memory attribute decoder: register offsets, fields, resets, counts
`ifndef MAD_MAP_VH
`define MAD_MAP_VH
// =====================================
// register offsets
`define MAD_OFF_CTRL 8'h00
`define MAD_OFF_AUX 8'h04
`define MAD_OFF_STATUS 8'h08
`define MAD_OFF_MASK 8'h0c
`define MAD_OFF_FENCE_CNT 8'h10
// =====================================
// control register fields
`define MAD_CTRL_XLAT_BIT 0
`define MAD_CTRL_ALIGN_BIT 1
// auxiliary control: small store policy field
`define MAD_AUX_POL_LSB 4
`define MAD_AUX_POL_MSB 5
// small store policy encodings
`define MAD_POL_WB_RA 2'h0
`define MAD_POL_RSVD 2'h1
`define MAD_POL_WT_RA 2'h2
`define MAD_POL_WB_RWA 2'h3
// =====================================
// status bits
`define MAD_ST_ALIGN 0
`define MAD_ST_DABORT 1
`define MAD_ST_PABORT 2
`define MAD_ST_IMPRECISE 3
`define MAD_ST_BADENC 4
`define MAD_ST_W 5
// =====================================
// reset values
`define MAD_CTRL_RST 32'h0000_0000
`define MAD_AUX_RST 32'h0000_0000
`define MAD_MASK_RST 5'h00
// =====================================
// line size in bytes
`define MAD_LINE_BYTES 6'h20
`endif
